// file: inc/rtccf_regs.vh
// Register map, field positions and reset values of the compare and flag block.
`ifndef RTCCF_REGS_VH
`define RTCCF_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RTCCF_ADDR_W         8
`define RTCCF_OFS_CTRL       8'h00
`define RTCCF_OFS_COUNTER    8'h04
`define RTCCF_OFS_CMP_FIRST  8'h08
`define RTCCF_OFS_CMP_SECOND 8'h0C
`define RTCCF_OFS_FLAG_STAT  8'h10
`define RTCCF_OFS_FLAG_SET   8'h14
`define RTCCF_OFS_FLAG_CLR   8'h18
`define RTCCF_OFS_ENABLE     8'h1C

// ---------------------------------------------------------------
// Fields and values
// ---------------------------------------------------------------
`define RTCCF_COUNT_W        24
`define RTCCF_COUNT_ZERO     24'h000000
`define RTCCF_COUNT_ONE      24'h000001
`define RTCCF_COUNT_MAX      24'hFFFFFF
`define RTCCF_FLAG_W         3
`define RTCCF_FLAG_ZERO      3'h0
`define RTCCF_BIT_OVF        0
`define RTCCF_BIT_FIRST      1
`define RTCCF_BIT_SECOND     2
`define RTCCF_CTRL_RUN       0
`define RTCCF_CTRL_TOP       2
`define RTCCF_DATA_ZERO      32'h00000000
`define RTCCF_TICK_DIV       16'h0F42
`define RTCCF_TICK_ZERO      16'h0000
`define RTCCF_TICK_ONE       16'h0001

`endif

// file: src/rtccf_sync.v
// Two-flop level synchroniser used to carry compare values into the counting side.
module rtccf_sync (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Data
    input  wire [23:0] d,
    output reg  [23:0] q
);
    reg [23:0] meta_ff;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= 24'h000000;
            q       <= 24'h000000;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// file: src/rtccf_top.v
// Compare channels, event flags and interrupt of the real-time counter.
//
// How it works
// R1 - First compare register, 24 bits, resets zero.
// R2 - Second compare register, 24 bits, resets zero.
// R3 - Counter equals first compare: flag and event.
// R4 - Counter equals second compare: flag and event.
// R5 - Status bit 2 shows second match flag.
// R6 - Status bit 1 shows first match flag.
// R7 - Status bit 0 shows overflow flag.
// R8 - Set register bit 2 sets second flag.
// R9 - Set register bit 1 sets first flag.
// R10 - Set register bit 0 sets overflow flag.
// R11 - Software writes zero to reserved bits.
// R12 - Top select: wrap at max or first compare.
// R13 - Clear register bits clear matching flags.
// R14 - Interrupt only for enabled flags.
// R15 - Counter is 24-bit, resets zero, compared.
// R16 - Writing zero to set leaves flags.
// R17 - Compare writes synchronised before matching.
`include "rtccf_regs.vh"

module rtccf_top (
    // Clock and reset
    input  wire        SYS_CLK,
    input  wire        RESET_N,
    // Register port
    input  wire [7:0]  ADDR,
    input  wire [31:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [31:0] RDATA,
    // Events and interrupt
    output reg         MATCH_FIRST_EVT,
    output reg         MATCH_SECOND_EVT,
    output reg         IRQ
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function wr_hit;
        input [7:0] a;
        input [7:0] ofs;
        input       we;
        begin
            wr_hit = we && (a == ofs);
        end
    endfunction

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg  [23:0] cmp_first_ff;
    reg  [23:0] cmp_second_ff;
    reg  [2:0]  ctrl_ff;
    reg  [2:0]  flags_ff;
    reg  [2:0]  enable_ff;
    reg  [23:0] counter_ff;
    reg  [15:0] tick_ff;
    reg         hit_first_ff;
    reg         hit_second_ff;
    reg  [23:0] nxt_counter;
    reg  [2:0]  nxt_flags;
    reg  [31:0] nxt_rdata;
    wire [23:0] cmp_first_lf;
    wire [23:0] cmp_second_lf;
    wire        tick;
    wire        hit_first;
    wire        hit_second;
    wire        ovf_evt;
    wire        run;
    wire        top_first;

    assign run       = ctrl_ff[`RTCCF_CTRL_RUN];
    assign top_first = ctrl_ff[`RTCCF_CTRL_TOP];
    assign tick      = run && (tick_ff == `RTCCF_TICK_DIV);

    // ---------------------------------------------------------------
    // Software-written registers
    // ---------------------------------------------------------------
    // Bits above the field are dropped, so reserved bits written as one are harmless.
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cmp_first_ff  <= `RTCCF_COUNT_ZERO;
            cmp_second_ff <= `RTCCF_COUNT_ZERO;
            ctrl_ff       <= `RTCCF_FLAG_ZERO;
            enable_ff     <= `RTCCF_FLAG_ZERO;
        end else begin
            if (wr_hit(ADDR, `RTCCF_OFS_CMP_FIRST, WR)) begin
                cmp_first_ff <= WDATA[23:0]; // R1
            end
            if (wr_hit(ADDR, `RTCCF_OFS_CMP_SECOND, WR)) begin
                cmp_second_ff <= WDATA[23:0]; // R2
            end
            if (wr_hit(ADDR, `RTCCF_OFS_CTRL, WR)) begin
                ctrl_ff <= WDATA[2:0];
            end
            if (wr_hit(ADDR, `RTCCF_OFS_ENABLE, WR)) begin
                enable_ff <= WDATA[2:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Compare value crossing
    // ---------------------------------------------------------------
    // The compare path sees values two cycles late; all 24 bits pass the same two
    // SYS_CLK flops together, so a new value is never seen half-updated.
    rtccf_sync u_sync_first (
        .clk     (SYS_CLK),
        .reset_n (RESET_N),
        .d       (cmp_first_ff),
        .q       (cmp_first_lf)
    ); // R17

    rtccf_sync u_sync_second (
        .clk     (SYS_CLK),
        .reset_n (RESET_N),
        .d       (cmp_second_ff),
        .q       (cmp_second_lf)
    ); // R17

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    // The low-frequency tick comes from a divider of the system clock.
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_ff <= `RTCCF_TICK_ZERO;
        end else if (!run || tick) begin
            tick_ff <= `RTCCF_TICK_ZERO;
        end else begin
            tick_ff <= tick_ff + `RTCCF_TICK_ONE;
        end
    end

    assign hit_first  = run && (counter_ff == cmp_first_lf); // R3 R15
    assign hit_second = run && (counter_ff == cmp_second_lf); // R4 R15
    assign ovf_evt    = tick && !top_first && (counter_ff == `RTCCF_COUNT_MAX);

    always @* begin
        nxt_counter = counter_ff;
        if (!run) begin
            nxt_counter = `RTCCF_COUNT_ZERO;
        end else if (tick) begin
            if (top_first && hit_first) begin
                nxt_counter = `RTCCF_COUNT_ZERO; // R12
            end else begin
                nxt_counter = counter_ff + `RTCCF_COUNT_ONE; // R12
            end
        end
    end

    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            counter_ff    <= `RTCCF_COUNT_ZERO; // R15
            hit_first_ff  <= 1'b0;
            hit_second_ff <= 1'b0;
        end else begin
            counter_ff    <= nxt_counter;
            hit_first_ff  <= hit_first;
            hit_second_ff <= hit_second;
        end
    end

    // ---------------------------------------------------------------
    // Event flags
    // ---------------------------------------------------------------
    // Match events fire on the rising edge of equality, so a counter resting
    // on a compare value gives one event only. Set beats clear.
    always @* begin
        nxt_flags = flags_ff;
        if (wr_hit(ADDR, `RTCCF_OFS_FLAG_CLR, WR)) begin
            nxt_flags = nxt_flags & ~WDATA[2:0]; // R13
        end
        if (wr_hit(ADDR, `RTCCF_OFS_FLAG_SET, WR)) begin
            nxt_flags = nxt_flags | WDATA[2:0]; // R8 R9 R10 R16
        end
        if (hit_first && !hit_first_ff) begin
            nxt_flags[`RTCCF_BIT_FIRST] = 1'b1; // R3 R6
        end
        if (hit_second && !hit_second_ff) begin
            nxt_flags[`RTCCF_BIT_SECOND] = 1'b1; // R4 R5
        end
        if (ovf_evt) begin
            nxt_flags[`RTCCF_BIT_OVF] = 1'b1; // R7
        end
    end

    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_ff         <= `RTCCF_FLAG_ZERO;
            MATCH_FIRST_EVT  <= 1'b0;
            MATCH_SECOND_EVT <= 1'b0;
            IRQ              <= 1'b0;
        end else begin
            flags_ff         <= nxt_flags;
            MATCH_FIRST_EVT  <= hit_first && !hit_first_ff; // R3
            MATCH_SECOND_EVT <= hit_second && !hit_second_ff; // R4
            IRQ              <= |(nxt_flags & enable_ff); // R14
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    always @* begin
        nxt_rdata = `RTCCF_DATA_ZERO;
        if (RD) begin
            case (ADDR)
                `RTCCF_OFS_CTRL:       nxt_rdata[2:0]  = ctrl_ff;
                `RTCCF_OFS_COUNTER:    nxt_rdata[23:0] = counter_ff; // R15
                `RTCCF_OFS_CMP_FIRST:  nxt_rdata[23:0] = cmp_first_ff; // R1
                `RTCCF_OFS_CMP_SECOND: nxt_rdata[23:0] = cmp_second_ff; // R2
                `RTCCF_OFS_FLAG_STAT:  nxt_rdata[2:0]  = flags_ff; // R5 R6 R7
                `RTCCF_OFS_ENABLE:     nxt_rdata[2:0]  = enable_ff;
                default:               nxt_rdata       = `RTCCF_DATA_ZERO;
            endcase
        end
    end

    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= `RTCCF_DATA_ZERO;
        end else begin
            RDATA <= nxt_rdata;
        end
    end
endmodule

// file: tb/rtccf_assertions.sv
// Port-level checks of the compare and flag block.
module rtccf_assertions (
    // Clock and register port
    input wire        SYS_CLK,
    input wire        RESET_N,
    input wire [7:0]  ADDR,
    input wire [31:0] WDATA,
    input wire        WR,
    input wire        RD,
    // Outputs
    input wire [31:0] RDATA,
    input wire        MATCH_FIRST_EVT,
    input wire        MATCH_SECOND_EVT,
    input wire        IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    sequence s_set(int b); WR && ADDR == 8'h14 && WDATA[2:0] == (3'h1 << b); endsequence
    sequence s_stat; RD && ADDR == 8'h10; endsequence
    property p_set_ovf; s_set(0) ##1 s_stat |=> RDATA[0]; endproperty
    a_set_ovf: assert property (p_set_ovf) else $error("overflow flag not set");
    property p_set_first; s_set(1) ##1 s_stat |=> RDATA[1]; endproperty
    a_set_first: assert property (p_set_first) else $error("first flag not set");
    property p_set_second; s_set(2) ##1 s_stat |=> RDATA[2]; endproperty
    a_set_second: assert property (p_set_second) else $error("second flag not set");
    property p_clr; WR && ADDR == 8'h18 && WDATA[2:0] == 3'h7 ##1 s_stat |=> RDATA[2:0] == 3'h0; endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared");
    property p_stat_upper; s_stat |=> RDATA[31:3] == 29'h0; endproperty
    a_stat_upper: assert property (p_stat_upper) else $error("status upper bits set");
    property p_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    property p_first_pulse; MATCH_FIRST_EVT |=> !MATCH_FIRST_EVT; endproperty
    a_first_pulse: assert property (p_first_pulse) else $error("first event too long");
    property p_second_pulse; MATCH_SECOND_EVT |=> !MATCH_SECOND_EVT; endproperty
    a_second_pulse: assert property (p_second_pulse) else $error("second event too long");
    property p_mask; WR && ADDR == 8'h1C && WDATA[2:0] == 3'h0 |-> ##2 !IRQ; endproperty
    a_mask: assert property (p_mask) else $error("interrupt while masked");
endmodule

// file: tb/rtccf_top_bench.sv
// Self-checking bench of the compare and flag block.
module rtccf_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata, d;
    logic        evt1, evt2, irq;
    int          errors = 0, compares = 0, cycles = 0;
    rtccf_top i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .MATCH_FIRST_EVT(evt1), .MATCH_SECOND_EVT(evt2), .IRQ(irq));
    always #4 sys_clk = ~sys_clk;
    // The tests wait about five counter ticks of 3907 cycles each.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            complete_run();
        end
    end
    // ---------------------------------------------------------------
    // Bus and compare tasks
    // ---------------------------------------------------------------
    task wr_reg(input [7:0] a, input [31:0] v);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [7:0] a);
        rd <= 1'b1; addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
        @(posedge sys_clk);
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_evt(input bit second);
        int n;
        for (n = 0; n < 9000 && !(second ? evt2 : evt1); n++) begin
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        chk(n < 9000, 1);
    endtask
    task complete_run();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task t_regs();
        rd_reg(8'h08); chk(d, 32'h0);
        rd_reg(8'h0C); chk(d, 32'h0);
        wr_reg(8'h08, 32'h000002);
        wr_reg(8'h0C, 32'h000003);
        rd_reg(8'h08); chk(d, 32'h2);
        rd_reg(8'h0C); chk(d, 32'h3);
        rd_reg(8'h40); chk(d, 32'h0);
        $display("regs done");
    endtask
    task t_flags();
        logic [31:0] e;
        e = 32'h0;
        wr_reg(8'h18, 32'h7);
        rd_reg(8'h10); chk(d, 32'h0);
        wr_reg(8'h1C, 32'h7);
        wr_reg(8'h14, 32'h0);
        rd_reg(8'h10); chk(d, e);
        for (int i = 0; i < 3; i++) begin
            e = e | (32'h1 << i);
            wr_reg(8'h14, 32'h1 << i);
            rd_reg(8'h10); chk(d, e);
            chk(irq, 1);
        end
        wr_reg(8'h1C, 32'h0);
        rd_reg(8'h14); chk(irq, 0);
        wr_reg(8'h18, 32'h7);
        wr_reg(8'h10, 32'h7);
        rd_reg(8'h10); chk(d, 32'h0);
        $display("flags done");
    endtask
    task t_match();
        wr_reg(8'h1C, 32'h7);
        wr_reg(8'h00, 32'h1);
        wait_evt(0);
        rd_reg(8'h10); chk(d, 32'h2);
        chk(irq, 1);
        wait_evt(1);
        rd_reg(8'h10); chk(d, 32'h6);
        rd_reg(8'h04); chk(d, 32'h3);
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h08, 32'h1);
        wr_reg(8'h00, 32'h5);
        wait_evt(0);
        repeat (3907) @(posedge sys_clk);
        rd_reg(8'h04); chk(d, 32'h0);
        $display("match done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_flags();
        t_match();
        complete_run();
    end
endmodule
bind rtccf_top rtccf_assertions i_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .MATCH_FIRST_EVT(MATCH_FIRST_EVT), .MATCH_SECOND_EVT(MATCH_SECOND_EVT),
    .IRQ(IRQ));
